/* File: bsw_params.svh */
`ifndef BSW_PARAMS_SVH
`define BSW_PARAMS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define BSW_DATA_W 36
`define BSW_ADDR_W 20
`define BSW_MEM_AW 22
`define BSW_LANES 4
`define BSW_LANE_W 9
`define BSW_LANES_X18 2
`define BSW_LANES_X9 1
`define BSW_NIB_W 4
`define BSW_BURST 4
`define BSW_BURST_W 144
`define BSW_SEL_W 16

// ----------------------------------------------------------------------
// device burst trackers, counted in link clock rises
// ----------------------------------------------------------------------
`define BSW_WR_START 3'h5
`define BSW_WR_FIRST 3'h4
`define BSW_RD_START 3'h7
`define BSW_RD_FIRST 3'h5
`define BSW_RD_LAST 3'h2
`define BSW_TRK_IDLE 3'h0
`define BSW_TRK_ONE 3'h1

// ----------------------------------------------------------------------
// controller write beat counter and read capture
// ----------------------------------------------------------------------
`define BSW_CW_FIRST 3'h2
`define BSW_CW_LAST 3'h5
`define BSW_CW_ONE 3'h1
`define BSW_CW_IDLE 3'h0
`define BSW_RC_LAST 2'h3
`define BSW_RC_ONE 2'h1

`endif

/* File: bsw_pkg.sv */
package bsw_pkg;

  // ----------------------------------------------------------------------
  // organisation and operation types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    bsw_org_x8  = 2'h0,
    bsw_org_x9  = 2'h1,
    bsw_org_x18 = 2'h2,
    bsw_org_x36 = 2'h3
  } bsw_org_t;

  typedef enum logic [1:0] {
    bsw_op_none = 2'h0,
    bsw_op_rd   = 2'h1,
    bsw_op_wr   = 2'h2
  } bsw_op_t;

endpackage

/* File: bsw_if.sv */
`timescale 1ns/1ps
`include "bsw_params.svh"

interface bsw_if;
  logic                   k;
  logic                   k_n;
  logic [`BSW_ADDR_W-1:0] addr;
  logic                   read_port_select_n;
  logic                   write_port_select_n;
  logic [`BSW_DATA_W-1:0] d;
  logic                   lane0_write_select_n;
  logic                   lane1_write_select_n;
  logic                   lane2_write_select_n;
  logic                   lane3_write_select_n;
  logic                   low_nibble_write_select_n;
  logic                   high_nibble_write_select_n;
  logic [`BSW_DATA_W-1:0] q;
  logic                   q_oe_n;

  modport dev (
    input  k,
    input  k_n,
    input  addr,
    input  read_port_select_n,
    input  write_port_select_n,
    input  d,
    input  lane0_write_select_n,
    input  lane1_write_select_n,
    input  lane2_write_select_n,
    input  lane3_write_select_n,
    input  low_nibble_write_select_n,
    input  high_nibble_write_select_n,
    output q,
    output q_oe_n
  );

  modport ctrl (
    output k,
    output k_n,
    output addr,
    output read_port_select_n,
    output write_port_select_n,
    output d,
    output lane0_write_select_n,
    output lane1_write_select_n,
    output lane2_write_select_n,
    output lane3_write_select_n,
    output low_nibble_write_select_n,
    output high_nibble_write_select_n,
    input  q,
    input  q_oe_n
  );
endinterface

/* File: bsw_sram.sv */
`timescale 1ns/1ps
`include "bsw_params.svh"

// Function
// R1 - x8: nibble selects gate bits 3:0, 7:4
// R2 - x18: two lane selects gate 8:0, 17:9
// R3 - x36: four lane selects gate nine-bit lanes
// R4 - x9: one select gates all nine bits
// R5 - all selects low writes whole word
// R6 - all selects high writes nothing
// R7 - selects sampled on both clock rises
// R8 - controller may vary selects between beats
// R9 - same-type starts on consecutive rises: ignore second
// R10 - select used last cycle is don't care
// R11 - reset: ports deselected, outputs disabled
// R12 - burst timed from start cycle t
// R13 - hold both clocks high while stopped
// R14 - write beats at t+1 and t+2 rises
// R15 - both selected from idle: read first, alternate
// R16 - each beat masks only its own word

module bsw_sram #(
  parameter bsw_pkg::bsw_org_t ORG = bsw_pkg::bsw_org_x36
) (
  input  logic                   core_clk,
  input  logic                   rst,
  bsw_if.dev                     link,
  output logic                   wr_strobe_q,
  output logic [`BSW_DATA_W-1:0] wr_mask_q
);

  // ----------------------------------------------------------------------
  // lanes in use per organisation
  // ----------------------------------------------------------------------
  localparam int LANES = (ORG == bsw_pkg::bsw_org_x36) ? `BSW_LANES :
                         (ORG == bsw_pkg::bsw_org_x18) ? `BSW_LANES_X18 :
                                                         `BSW_LANES_X9;

  logic                   k_prev_q;
  logic                   k_prev_d;
  logic                   kn_prev_q;
  logic                   kn_prev_d;
  logic                   k_rise;
  logic                   kn_rise;
  logic                   edge_ev;
  logic [`BSW_LANES-1:0]  lane_en;
  logic [1:0]             nib_en;
  logic [`BSW_DATA_W-1:0] wmask;

  bsw_pkg::bsw_op_t       last_q;
  bsw_pkg::bsw_op_t       last_d;
  logic                   start_r;
  logic                   start_w;

  logic [2:0]             wl_q [2];
  logic [2:0]             wl_d [2];
  logic [`BSW_ADDR_W-1:0] wa_q [2];
  logic [`BSW_ADDR_W-1:0] wa_d [2];
  logic [2:0]             rl_q [2];
  logic [2:0]             rl_d [2];
  logic [`BSW_ADDR_W-1:0] ra_q [2];
  logic [`BSW_ADDR_W-1:0] ra_d [2];

  logic                   mem_we;
  logic [`BSW_MEM_AW-1:0] mem_wa;
  logic                   mem_re;
  logic [`BSW_MEM_AW-1:0] mem_ra;
  logic [`BSW_DATA_W-1:0] mem_rdata;
  logic [`BSW_DATA_W-1:0] q_q;
  logic [`BSW_DATA_W-1:0] q_d;
  logic                   q_oe_n_q;
  logic                   q_oe_n_d;
  logic                   wr_strobe_d;
  logic [`BSW_DATA_W-1:0] wr_mask_d;

  logic [`BSW_DATA_W-1:0] mem [0:(1<<`BSW_MEM_AW)-1];

  assign link.q      = q_q;
  assign link.q_oe_n = q_oe_n_q;

  // ----------------------------------------------------------------------
  // clock rise detection
  // ----------------------------------------------------------------------
  assign k_rise  = link.k & ~k_prev_q;
  assign kn_rise = link.k_n & ~kn_prev_q;
  assign edge_ev = k_rise | kn_rise; // R7
  assign k_prev_d  = link.k;
  assign kn_prev_d = link.k_n;

  // ----------------------------------------------------------------------
  // per-bit write mask
  // ----------------------------------------------------------------------
  assign lane_en = ~{link.lane3_write_select_n, link.lane2_write_select_n,
                     link.lane1_write_select_n, link.lane0_write_select_n};
  assign nib_en  = ~{link.high_nibble_write_select_n,
                     link.low_nibble_write_select_n};

  for (genvar b = 0; b < `BSW_DATA_W; b++) begin : g_mask
    if (ORG == bsw_pkg::bsw_org_x8) begin : g_nib
      if (b < 2 * `BSW_NIB_W) begin : g_on
        assign wmask[b] = nib_en[b / `BSW_NIB_W]; // R1
      end else begin : g_off
        assign wmask[b] = 1'b0;
      end
    end else if (b / `BSW_LANE_W < LANES) begin : g_lane
      assign wmask[b] = lane_en[b / `BSW_LANE_W]; // R2 R3 R4 R5 R6
    end else begin : g_off
      assign wmask[b] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // start decode and port arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    start_r = k_rise & ~link.read_port_select_n &
              (last_q != bsw_pkg::bsw_op_rd); // R9 R10
    start_w = k_rise & ~link.write_port_select_n &
              (last_q != bsw_pkg::bsw_op_wr) & ~start_r; // R9 R10 R15
    last_d = last_q;
    if (k_rise) begin
      if (start_r) begin
        last_d = bsw_pkg::bsw_op_rd;
      end else if (start_w) begin
        last_d = bsw_pkg::bsw_op_wr;
      end else begin
        last_d = bsw_pkg::bsw_op_none;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read beat address, one word per link clock rise
  // ----------------------------------------------------------------------
  always_comb begin
    mem_re = 1'b0;
    mem_ra = '0;
    for (int s = 0; s < 2; s++) begin
      if (edge_ev && rl_q[s] <= `BSW_RD_FIRST &&
          rl_q[s] >= `BSW_RD_LAST) begin
        mem_re = 1'b1;
        mem_ra = {ra_q[s], 2'(`BSW_RD_FIRST - rl_q[s])}; // R12
      end
    end
  end

  assign mem_rdata = mem[mem_ra];

  // ----------------------------------------------------------------------
  // burst trackers, two per port
  // ----------------------------------------------------------------------
  always_comb begin
    mem_we   = 1'b0;
    mem_wa   = '0;
    q_d      = q_q;
    q_oe_n_d = q_oe_n_q;
    if (edge_ev) begin
      q_oe_n_d = 1'b1;
    end
    for (int s = 0; s < 2; s++) begin
      wl_d[s] = wl_q[s];
      wa_d[s] = wa_q[s];
      rl_d[s] = rl_q[s];
      ra_d[s] = ra_q[s];
      if (edge_ev && wl_q[s] != `BSW_TRK_IDLE) begin
        wl_d[s] = wl_q[s] - `BSW_TRK_ONE; // R12
        if (wl_q[s] <= `BSW_WR_FIRST) begin
          mem_we = 1'b1; // R14
          mem_wa = {wa_q[s], 2'(`BSW_WR_FIRST - wl_q[s])}; // R16
        end
      end
      if (edge_ev && rl_q[s] != `BSW_TRK_IDLE) begin
        rl_d[s] = rl_q[s] - `BSW_TRK_ONE; // R12
      end
    end
    if (mem_re) begin
      q_oe_n_d = 1'b0;
      q_d      = mem_rdata;
    end
    if (start_w) begin
      if (wl_q[0] == `BSW_TRK_IDLE) begin
        wl_d[0] = `BSW_WR_START;
        wa_d[0] = link.addr;
      end else begin
        wl_d[1] = `BSW_WR_START;
        wa_d[1] = link.addr;
      end
    end
    if (start_r) begin
      if (rl_q[0] == `BSW_TRK_IDLE) begin
        rl_d[0] = `BSW_RD_START;
        ra_d[0] = link.addr;
      end else begin
        rl_d[1] = `BSW_RD_START;
        ra_d[1] = link.addr;
      end
    end
    wr_strobe_d = mem_we;
    wr_mask_d   = mem_we ? wmask : wr_mask_q;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      k_prev_q    <= 1'b1;
      kn_prev_q   <= 1'b1;
      last_q      <= bsw_pkg::bsw_op_none; // R11
      q_q         <= '0;
      q_oe_n_q    <= 1'b1; // R11
      wr_strobe_q <= 1'b0;
      wr_mask_q   <= '0;
      for (int s = 0; s < 2; s++) begin
        wl_q[s] <= `BSW_TRK_IDLE;
        wa_q[s] <= '0;
        rl_q[s] <= `BSW_TRK_IDLE;
        ra_q[s] <= '0;
      end
    end else begin
      k_prev_q    <= k_prev_d;
      kn_prev_q   <= kn_prev_d;
      last_q      <= last_d;
      q_q         <= q_d;
      q_oe_n_q    <= q_oe_n_d;
      wr_strobe_q <= wr_strobe_d;
      wr_mask_q   <= wr_mask_d;
      for (int s = 0; s < 2; s++) begin
        wl_q[s] <= wl_d[s];
        wa_q[s] <= wa_d[s];
        rl_q[s] <= rl_d[s];
        ra_q[s] <= ra_d[s];
      end
    end
  end

  // ----------------------------------------------------------------------
  // masked array write, unselected lanes keep contents
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= (mem[mem_wa] & ~wmask) | (link.d & wmask); // R2 R6
    end
  end

endmodule

/* File: bsw_ctrl.sv */
`timescale 1ns/1ps
`include "bsw_params.svh"

module bsw_ctrl (
  input  logic                   core_clk,
  input  logic                   rst,
  bsw_if.ctrl                    link,
  input  logic                   rd_req,
  input  logic [`BSW_ADDR_W-1:0] rd_addr,
  output logic                   rd_ready_q,
  input  logic                   wr_req,
  input  logic [`BSW_ADDR_W-1:0] wr_addr,
  input  logic [`BSW_BURST_W-1:0] wr_data,
  input  logic [`BSW_SEL_W-1:0]  wr_sel_n,
  output logic                   wr_ready_q,
  output logic                   rd_valid_q,
  output logic [`BSW_BURST_W-1:0] rd_data_q
);

  logic                    k_q;
  logic                    k_d;
  logic                    kn_q;
  logic                    kn_d;
  logic [`BSW_ADDR_W-1:0]  addr_q;
  logic [`BSW_ADDR_W-1:0]  addr_d;
  logic                    rps_n_q;
  logic                    rps_n_d;
  logic                    wps_n_q;
  logic                    wps_n_d;
  logic [`BSW_DATA_W-1:0]  d_q;
  logic [`BSW_DATA_W-1:0]  d_d;
  logic [`BSW_LANES-1:0]   sel_n_q;
  logic [`BSW_LANES-1:0]   sel_n_d;
  bsw_pkg::bsw_op_t        last_q;
  bsw_pkg::bsw_op_t        last_d;
  logic                    rd_ready_d;
  logic                    wr_ready_d;
  logic [2:0]              wcnt_q;
  logic [2:0]              wcnt_d;
  logic [`BSW_BURST_W-1:0] wbuf_q;
  logic [`BSW_BURST_W-1:0] wbuf_d;
  logic [`BSW_SEL_W-1:0]   wsel_q;
  logic [`BSW_SEL_W-1:0]   wsel_d;
  logic [1:0]              rcnt_q;
  logic [1:0]              rcnt_d;
  logic [`BSW_BURST_W-1:0] rbuf_q;
  logic [`BSW_BURST_W-1:0] rbuf_d;
  logic                    rd_valid_d;
  logic [`BSW_BURST_W-1:0] rd_data_d;
  logic                    start;
  logic                    rd_take;
  logic                    wr_take;
  logic [1:0]              beat;

  assign link.k                          = k_q;
  assign link.k_n                        = kn_q;
  assign link.addr                       = addr_q;
  assign link.read_port_select_n         = rps_n_q;
  assign link.write_port_select_n        = wps_n_q;
  assign link.d                          = d_q;
  assign link.lane0_write_select_n       = sel_n_q[0];
  assign link.lane1_write_select_n       = sel_n_q[1];
  assign link.lane2_write_select_n       = sel_n_q[2];
  assign link.lane3_write_select_n       = sel_n_q[3];
  assign link.low_nibble_write_select_n  = sel_n_q[0];
  assign link.high_nibble_write_select_n = sel_n_q[1];

  // ----------------------------------------------------------------------
  // link clock, start scheduling, write beats
  // ----------------------------------------------------------------------
  always_comb begin
    k_d     = ~k_q;
    kn_d    = k_q;
    start   = ~k_q;
    rd_take = start & rd_req & rd_ready_q;
    wr_take = start & wr_req & wr_ready_q & ~rd_take;
    rps_n_d = ~rd_take;
    wps_n_d = ~wr_take;
    addr_d  = rd_take ? rd_addr : (wr_take ? wr_addr : addr_q);
    last_d  = last_q;
    if (start) begin
      last_d = rd_take ? bsw_pkg::bsw_op_rd :
               (wr_take ? bsw_pkg::bsw_op_wr : bsw_pkg::bsw_op_none);
    end
    rd_ready_d = k_q & (last_q != bsw_pkg::bsw_op_rd); // R9
    wr_ready_d = k_q & (last_q != bsw_pkg::bsw_op_wr) &
                 (wcnt_q == `BSW_CW_IDLE || wcnt_q == `BSW_CW_LAST); // R9
    wbuf_d = wr_take ? wr_data : wbuf_q;
    wsel_d = wr_take ? wr_sel_n : wsel_q;
    wcnt_d = wcnt_q;
    if (wr_take) begin
      wcnt_d = `BSW_CW_ONE;
    end else if (wcnt_q == `BSW_CW_LAST) begin
      wcnt_d = `BSW_CW_IDLE;
    end else if (wcnt_q != `BSW_CW_IDLE) begin
      wcnt_d = wcnt_q + `BSW_CW_ONE;
    end
    beat    = 2'(wcnt_q - `BSW_CW_FIRST);
    d_d     = '0;
    sel_n_d = '1;
    if (wcnt_q >= `BSW_CW_FIRST) begin
      d_d     = wbuf_q[`BSW_DATA_W*beat +: `BSW_DATA_W]; // R14
      sel_n_d = wsel_q[`BSW_LANES*beat +: `BSW_LANES]; // R7 R8
    end
  end

  // ----------------------------------------------------------------------
  // read beat capture
  // ----------------------------------------------------------------------
  always_comb begin
    rbuf_d     = rbuf_q;
    rcnt_d     = rcnt_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    if (!link.q_oe_n) begin
      rbuf_d[`BSW_DATA_W*rcnt_q +: `BSW_DATA_W] = link.q; // R12
      rcnt_d = rcnt_q + `BSW_RC_ONE;
      if (rcnt_q == `BSW_RC_LAST) begin
        rd_valid_d = 1'b1;
        rd_data_d  = rbuf_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      k_q        <= 1'b1; // R13
      kn_q       <= 1'b1; // R13
      addr_q     <= '0;
      rps_n_q    <= 1'b1;
      wps_n_q    <= 1'b1;
      d_q        <= '0;
      sel_n_q    <= '1;
      last_q     <= bsw_pkg::bsw_op_none;
      rd_ready_q <= 1'b0;
      wr_ready_q <= 1'b0;
      wcnt_q     <= `BSW_CW_IDLE;
      wbuf_q     <= '0;
      wsel_q     <= '1;
      rcnt_q     <= '0;
      rbuf_q     <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      k_q        <= k_d;
      kn_q       <= kn_d;
      addr_q     <= addr_d;
      rps_n_q    <= rps_n_d;
      wps_n_q    <= wps_n_d;
      d_q        <= d_d;
      sel_n_q    <= sel_n_d;
      last_q     <= last_d;
      rd_ready_q <= rd_ready_d;
      wr_ready_q <= wr_ready_d;
      wcnt_q     <= wcnt_d;
      wbuf_q     <= wbuf_d;
      wsel_q     <= wsel_d;
      rcnt_q     <= rcnt_d;
      rbuf_q     <= rbuf_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
    end
  end

endmodule

/* File: bsw_link_asserts.sv */
`timescale 1ns/1ps

module bsw_link_asserts (
  input logic core_clk,
  input logic rst,
  input logic k,
  input logic k_n,
  input logic read_port_select_n,
  input logic write_port_select_n,
  input logic lane0_write_select_n,
  input logic lane1_write_select_n,
  input logic lane2_write_select_n,
  input logic lane3_write_select_n,
  input logic low_nibble_write_select_n,
  input logic high_nibble_write_select_n,
  input logic q_oe_n
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic sel_high;
  assign sel_high = lane0_write_select_n & lane1_write_select_n &
                    lane2_write_select_n & lane3_write_select_n;

  sequence wr_start_s;
    $rose(k) && !write_port_select_n;
  endsequence
  sequence rd_start_s;
    $rose(k) && !read_port_select_n;
  endsequence
  sequence rd_beats_s;
    (!q_oe_n) [*4];
  endsequence
  sequence wr_frame_s;
    sel_high ##1 sel_high ##5 sel_high;
  endsequence

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_RST_IDLE: assert property ($fell(rst) |-> q_oe_n &&
    write_port_select_n && read_port_select_n) else $error("not idle");
  AST_RD_OE: assert property (rd_start_s |-> ##4 rd_beats_s)
    else $error("read data window wrong");
  AST_RD_SPACE: assert property (rd_start_s |-> ##2 read_port_select_n)
    else $error("reads on consecutive rises");
  AST_WR_SPACE: assert property (wr_start_s |-> ##2 write_port_select_n)
    else $error("writes on consecutive rises");
  AST_WR_FRAME: assert property (wr_start_s |-> wr_frame_s)
    else $error("lane selects outside data beats");
  AST_START_K: assert property (!write_port_select_n ||
    !read_port_select_n |-> k) else $error("start off the k rise");
  AST_RD_ONE: assert property (!read_port_select_n |=>
    read_port_select_n) else $error("read select held");
  AST_K_PAIR: assert property (!$past(rst) |-> (k_n == !k) &&
    (k != $past(k))) else $error("link clocks wrong");
  AST_NIB_MAP: assert property ((low_nibble_write_select_n ==
    lane0_write_select_n) && (high_nibble_write_select_n ==
    lane1_write_select_n)) else $error("nibble selects differ");
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "bsw_params.svh"

module tb_top;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic                    core_clk = 1'h0;
  logic                    rst = 1'h1;
  logic                    rd_req, wr_req, rd_ready_q, wr_ready_q;
  logic                    rd_valid_q, wr_strobe_q, x8_strobe_q;
  logic [`BSW_ADDR_W-1:0]  rd_addr, wr_addr;
  logic [`BSW_BURST_W-1:0] wr_data, rd_data_q, pat_a, pat_b;
  logic [`BSW_SEL_W-1:0]   wr_sel_n;
  logic [`BSW_DATA_W-1:0]  wr_mask_q, x8_mask_q;
  int                      errors = 0;
  int                      n_tests = 0;

  bsw_if bsw_if_i ();
  bsw_if bsw_if_x8_i ();

  always #5 core_clk = ~core_clk;

  bsw_sram #(.ORG(bsw_pkg::bsw_org_x36)) bsw_sram_i (.core_clk(core_clk),
    .rst(rst), .link(bsw_if_i), .wr_strobe_q(wr_strobe_q),
    .wr_mask_q(wr_mask_q));
  bsw_sram #(.ORG(bsw_pkg::bsw_org_x8)) bsw_sram_x8_i (.core_clk(core_clk),
    .rst(rst), .link(bsw_if_x8_i), .wr_strobe_q(x8_strobe_q),
    .wr_mask_q(x8_mask_q));
  bsw_ctrl bsw_ctrl_i (.core_clk(core_clk), .rst(rst), .link(bsw_if_i),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready_q(rd_ready_q),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_sel_n(wr_sel_n), .wr_ready_q(wr_ready_q), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q));
  bsw_link_asserts bsw_link_asserts_i (.core_clk(core_clk), .rst(rst),
    .k(bsw_if_i.k), .k_n(bsw_if_i.k_n),
    .read_port_select_n(bsw_if_i.read_port_select_n),
    .write_port_select_n(bsw_if_i.write_port_select_n),
    .lane0_write_select_n(bsw_if_i.lane0_write_select_n),
    .lane1_write_select_n(bsw_if_i.lane1_write_select_n),
    .lane2_write_select_n(bsw_if_i.lane2_write_select_n),
    .lane3_write_select_n(bsw_if_i.lane3_write_select_n),
    .low_nibble_write_select_n(bsw_if_i.low_nibble_write_select_n),
    .high_nibble_write_select_n(bsw_if_i.high_nibble_write_select_n),
    .q_oe_n(bsw_if_i.q_oe_n));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [`BSW_BURST_W-1:0] seen,
                       input logic [`BSW_BURST_W-1:0] exp,
                       input string msg);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [`BSW_BURST_W-1:0] merge(
    input logic [`BSW_BURST_W-1:0] old_v,
    input logic [`BSW_BURST_W-1:0] new_v,
    input logic [`BSW_SEL_W-1:0]   sel_n);
    logic [`BSW_BURST_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 16; b++) begin
      if (!sel_n[b]) r[9*b +: 9] = new_v[9*b +: 9];
    end
    return r;
  endfunction

  task automatic do_write(input logic [`BSW_ADDR_W-1:0] a,
                          input logic [`BSW_BURST_W-1:0] dat,
                          input logic [`BSW_SEL_W-1:0] sel);
    int n;
    @(posedge core_clk);
    wr_req <= 1'h1;
    wr_addr <= a;
    wr_data <= dat;
    wr_sel_n <= sel;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wr_ready_q !== 1'h1 && n < 40);
    wr_req <= 1'h0;
    check(n < 40, 1'h1, "write not taken");
  endtask

  task automatic do_read(input logic [`BSW_ADDR_W-1:0] a,
                         input logic [`BSW_BURST_W-1:0] exp);
    int n;
    @(posedge core_clk);
    rd_req <= 1'h1;
    rd_addr <= a;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rd_ready_q !== 1'h1 && n < 40);
    rd_req <= 1'h0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rd_valid_q !== 1'h1 && n < 60);
    check(rd_valid_q, 1'h1, "read not answered");
    check(rd_data_q, exp, "read data");
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check(bsw_if_i.q_oe_n, 1'h1, "output enable in reset");
    check(wr_strobe_q, 1'h0, "strobe in reset");
    check({bsw_if_i.k, bsw_if_i.k_n}, 2'h3, "clocks in reset");
  endtask

  task automatic t_full();
    do_write(20'h0_0005, pat_a, 16'h0000);
    do_read(20'h0_0005, pat_a);
  endtask

  task automatic t_mask();
    logic [`BSW_SEL_W-1:0]  sel;
    logic [`BSW_DATA_W-1:0] m;
    sel = 16'h7F5E;
    do_write(20'h0_0005, pat_b, sel);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      for (int l = 0; l < 4; l++) m[9*l +: 9] = {9{!sel[4*i+l]}};
      check(wr_strobe_q, 1'h1, "x36 strobe");
      check(wr_mask_q, m, "x36 mask");
    end
    @(negedge core_clk);
    check(wr_strobe_q, 1'h0, "x36 strobe after burst");
    do_read(20'h0_0005, merge(pat_a, pat_b, 16'h7F5E));
  endtask

  task automatic t_both();
    for (int j = 0; j < 12; j++) begin
      @(posedge core_clk);
      bsw_if_x8_i.k <= j[0];
      bsw_if_x8_i.k_n <= ~j[0];
      bsw_if_x8_i.read_port_select_n <= !(j == 1 || j == 3);
      bsw_if_x8_i.write_port_select_n <= !(j == 1 || j == 3);
      bsw_if_x8_i.low_nibble_write_select_n <= 1'h0;
      bsw_if_x8_i.high_nibble_write_select_n <= 1'h0;
      @(negedge core_clk);
      check(bsw_if_x8_i.q_oe_n, !(j >= 5 && j <= 8), "read first");
      check(x8_strobe_q, (j >= 6 && j <= 9), "write second");
    end
  endtask

  task automatic t_x8();
    logic [7:0] sel;
    logic [1:0] s;
    sel = 8'h24;
    for (int j = 0; j < 14; j++) begin
      @(posedge core_clk);
      bsw_if_x8_i.k <= (j < 12) ? j[0] : 1'h1;
      bsw_if_x8_i.k_n <= (j < 12) ? ~j[0] : 1'h1;
      bsw_if_x8_i.write_port_select_n <= !(j == 1 || j == 3);
      s = (j > 6 && j < 11) ? 2'h0 : 2'h3;
      if (j >= 3 && j <= 6) s = sel[2*(j-3) +: 2];
      bsw_if_x8_i.low_nibble_write_select_n <= s[0];
      bsw_if_x8_i.high_nibble_write_select_n <= s[1];
      bsw_if_x8_i.d <= 36'(j) * 36'h0_0000_0011;
      @(negedge core_clk);
      check(x8_strobe_q, (j >= 4 && j <= 7), "x8 strobe");
      if (j >= 4 && j <= 7) begin
        s = sel[2*(j-4) +: 2];
        check(x8_mask_q, {28'h000_0000, {4{!s[1]}}, {4{!s[0]}}}, "x8 mask");
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rd_req = 1'h0;
    wr_req = 1'h0;
    rd_addr = '0;
    wr_addr = '0;
    wr_data = '0;
    wr_sel_n = '1;
    pat_a = {4{36'h9_8765_4321}};
    pat_b = {36'h1_2345_6789, 36'hF_EDCB_A987, 36'h5_A5A5_A5A5,
             36'h3_C3C3_C3C3};
    bsw_if_x8_i.k = 1'h1;
    bsw_if_x8_i.k_n = 1'h1;
    bsw_if_x8_i.addr = '0;
    bsw_if_x8_i.read_port_select_n = 1'h1;
    bsw_if_x8_i.write_port_select_n = 1'h1;
    bsw_if_x8_i.d = '0;
    bsw_if_x8_i.lane0_write_select_n = 1'h1;
    bsw_if_x8_i.lane1_write_select_n = 1'h1;
    bsw_if_x8_i.lane2_write_select_n = 1'h1;
    bsw_if_x8_i.lane3_write_select_n = 1'h1;
    bsw_if_x8_i.low_nibble_write_select_n = 1'h1;
    bsw_if_x8_i.high_nibble_write_select_n = 1'h1;
    repeat (10) @(posedge core_clk);
    t_reset();
    rst <= 1'h0;
    t_full();
    t_mask();
    t_x8();
    t_both();
    wrap_up();
  end

  initial begin
    #100_000;
    errors++;
    wrap_up();
  end
endmodule
